/* inc/ssdp_pkg.sv */
/*
 * Constants for the serial status, data and shared port block.
 * Assumes a 100 MHz system clock and APB register access, one word per register.
 */
package ssdp_pkg;

    // ----------------------------------------
    // Bus shape
    // ----------------------------------------
    localparam int APB_AW = 10;
    localparam int APB_DW = 32;
    localparam int BYTE_W = 8;

    // ----------------------------------------
    // Register indexes (byte address is four times the index)
    // ----------------------------------------
    localparam logic [7:0] IDX_CTRL_ONE = 8'hD0;
    localparam logic [7:0] IDX_STATUS = 8'hD3;
    localparam logic [7:0] IDX_DATA = 8'hD5;
    localparam logic [7:0] IDX_PORT = 8'hD6;
    localparam logic [7:0] IDX_DIR = 8'hD7;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int ST_DONE_BIT = 7;
    localparam int ST_WRITE_COLLISION_FLAG_BIT = 6;
    localparam int ST_MODE_FAULT_FLAG_BIT = 4;
    localparam int C1_IRQ_EN = 7;
    localparam int C1_ENABLE = 6;
    localparam int C1_MASTER = 4;
    localparam int C1_CPOL = 3;
    localparam int C1_SS_OUT_EN = 1;
    localparam int C1_LSB_FIRST = 0;

    // Shared port pin positions
    localparam int PIN_RX0 = 0;
    localparam int PIN_TX0 = 1;
    localparam int PIN_RX1 = 2;
    localparam int PIN_TX1 = 3;
    localparam int PIN_MISO = 4;
    localparam int PIN_MOSI = 5;
    localparam int PIN_SCK = 6;
    localparam int PIN_SS = 7;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'h00;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCK_HALF_NS = 40;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Transfer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LEAD = 4'b0010,
        ST_TRAIL = 4'b0100,
        ST_DONE = 4'b1000
    } ssdp_state_t;

endpackage

/* hw/ssdp_sync.sv */
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes the inputs are asynchronous to i_clock.
 */
`timescale 1ns/1ns
module ssdp_sync #(
    parameter int W = 8
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds only the second
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

/* hw/ssdp_shifter.sv */
/*
 * Eight bit serial shifter with a one bit input sample stage.
 * Assumes sample and shift strobes are one-cycle pulses on i_clock.
 */
`timescale 1ns/1ns
module ssdp_shifter
    import ssdp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_load,
    input wire logic [ssdp_pkg::BYTE_W-1:0] i_load_data,
    input wire logic i_sample,
    input wire logic i_shift,
    input wire logic i_serial_in,
    input wire logic i_lsb_first,
    output logic o_serial_out,
    output logic [ssdp_pkg::BYTE_W-1:0] o_data
);
    logic [BYTE_W-1:0] shift_q;
    logic in_bit_q;

    // No reset: contents survive reset
    always_ff @(posedge i_clock) begin
        if (i_load) begin
            shift_q <= i_load_data;
        end else if (i_shift) begin
            if (i_lsb_first) begin
                shift_q <= {in_bit_q, shift_q[BYTE_W-1:1]};
            end else begin
                shift_q <= {shift_q[BYTE_W-2:0], in_bit_q};
            end
        end
    end

    // Captured on the leading clock edge
    always_ff @(posedge i_clock) begin
        if (i_sample) begin
            in_bit_q <= i_serial_in;
        end
    end

    assign o_serial_out = i_lsb_first ? shift_q[0] : shift_q[BYTE_W-1];
    assign o_data = shift_q;
endmodule

/* hw/ssdp_top.sv */
/*
 * Serial peripheral status flags, data register and shared port pin logic.
 * Assumes an APB master on i_clock and an external serial device on the pins.
 */
`timescale 1ns/1ns
// Operation
// - Done flag after eighth clock cycle
// - Done clears: status read, data access
// - Busy write discarded, collision flag set
// - Collision clears: status read, data access
// - Master mode, select low sets fault
// - Pin seven output suppresses fault
// - Fault clears: status read, control write
// - Status readable, writes ignored
// - Data reads buffered, writes load shifter
// - Data register untouched by reset
// - Sixteen bit ring shifts eight places
// - Reset clears port direction
// - Port read: pin or driver level
// - Latch drives outputs, never serial outputs
// - Direction zero input, one output
// - Receiver active: pins two, zero input
// - Transmitter active: pins three, one output
// - SPI inputs forced, SPI outputs need direction
// - Slave: pin seven select input
// - Fault clears direction bits five-seven
// - Interrupt on done or fault
// - Fault reads master, enable as zero
module ssdp_top
    import ssdp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ssdp_pkg::APB_AW-1:0] i_paddr,
    input wire logic [ssdp_pkg::APB_DW-1:0] i_pwdata,
    output logic [ssdp_pkg::APB_DW-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [ssdp_pkg::BYTE_W-1:0] i_pin_in,
    output logic [ssdp_pkg::BYTE_W-1:0] o_pin_out,
    output logic [ssdp_pkg::BYTE_W-1:0] o_pin_oe,
    input wire logic i_async_rx_en,
    input wire logic i_async_tx_en,
    input wire logic [1:0] i_async_txd,
    output logic o_spi_irq
);
    import ssdp_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic pready_q;
    logic pslverr_q;
    logic [APB_DW-1:0] prdata_q;
    logic [7:0] idx;
    logic hit;
    logic acc;
    logic [BYTE_W-1:0] rd_byte;
    logic wr_ctrl;
    logic wr_data;
    logic wr_port;
    logic wr_dir;
    logic rd_status;
    logic data_acc;
    logic [BYTE_W-1:0] ctrl_q;
    logic [BYTE_W-1:0] dir_q;
    logic [BYTE_W-1:0] port_q;
    logic [BYTE_W-1:0] rx_buf_q;
    logic done_flag_q;
    logic write_collision_flag_flag_q;
    logic mode_fault_flag_flag_q;
    logic armed_done_q;
    logic armed_write_collision_flag_q;
    logic armed_mode_fault_flag_q;
    logic irq_q;
    logic [BYTE_W-1:0] pin_s;
    logic [BYTE_W-1:0] pin_out_q;
    logic [BYTE_W-1:0] pin_oe_q;
    logic [BYTE_W-1:0] pin_out_d;
    logic [BYTE_W-1:0] pin_oe_d;
    ssdp_state_t state_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] div_cnt_q;
    logic sck_prev_q;
    logic enable;
    logic master;
    logic busy;
    logic tick;
    logic lead_ev;
    logic trail_ev;
    logic abort;
    logic start;
    logic sample;
    logic shift;
    logic done;
    logic mode_fault_flag_set;
    logic write_collision_flag_set;
    logic ser_out;
    logic [BYTE_W-1:0] shift_data;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign idx = i_paddr[APB_AW-1:2];
    assign hit = (idx == IDX_CTRL_ONE) || (idx == IDX_STATUS) || (idx == IDX_DATA) ||
                 (idx == IDX_PORT) || (idx == IDX_DIR);
    assign acc = i_psel && i_penable && pready_q;
    assign wr_ctrl = acc && i_pwrite && (idx == IDX_CTRL_ONE);
    assign wr_data = acc && i_pwrite && (idx == IDX_DATA);
    assign wr_port = acc && i_pwrite && (idx == IDX_PORT);
    assign wr_dir = acc && i_pwrite && (idx == IDX_DIR);
    assign rd_status = acc && !i_pwrite && (idx == IDX_STATUS);
    assign data_acc = acc && (idx == IDX_DATA);

    // Read mux; status is read-only
    always_comb begin
        rd_byte = '0;
        case (idx)
            IDX_CTRL_ONE: rd_byte = ctrl_q;
            IDX_STATUS: begin
                rd_byte[ST_DONE_BIT] = done_flag_q;
                rd_byte[ST_WRITE_COLLISION_FLAG_BIT] = write_collision_flag_flag_q;
                rd_byte[ST_MODE_FAULT_FLAG_BIT] = mode_fault_flag_flag_q;
            end
            IDX_DATA: rd_byte = rx_buf_q;
            IDX_PORT: begin
                for (int b = 0; b < BYTE_W; b++) begin
                    rd_byte[b] = pin_oe_q[b] ? pin_out_q[b] : pin_s[b];
                end
            end
            IDX_DIR: rd_byte = dir_q;
            default: rd_byte = '0;
        endcase
    end

    // One wait state, then answer
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= i_psel && i_penable && !pready_q;
            if (i_psel && i_penable && !pready_q) begin
                prdata_q <= {{(APB_DW-BYTE_W){1'b0}}, rd_byte};
                pslverr_q <= !hit;
            end
        end
    end

    // ----------------------------------------
    // Control, direction and port latch
    // ----------------------------------------
    assign enable = ctrl_q[C1_ENABLE];
    assign master = ctrl_q[C1_MASTER];

    // Fault drops master and enable
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= CTRL_ONE_RST;
        end else if (mode_fault_flag_set) begin
            ctrl_q[C1_ENABLE] <= 1'b0;
            ctrl_q[C1_MASTER] <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_q <= i_pwdata[BYTE_W-1:0];
        end
    end

    // Direction register
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            dir_q <= DIR_RST;
        end else begin
            if (wr_dir) begin
                dir_q <= i_pwdata[BYTE_W-1:0];
            end
            if (mode_fault_flag_set) begin
                dir_q[PIN_SS:PIN_MOSI] <= 3'h0;
            end
        end
    end

    // Port data latch
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            port_q <= PORT_RST;
        end else if (wr_port) begin
            port_q <= i_pwdata[BYTE_W-1:0];
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    assign write_collision_flag_set = wr_data && busy;
    assign mode_fault_flag_set = master && !dir_q[PIN_SS] && !pin_s[PIN_SS] && !mode_fault_flag_flag_q;

    // Arming by a status read
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            armed_done_q <= 1'b0;
            armed_write_collision_flag_q <= 1'b0;
            armed_mode_fault_flag_q <= 1'b0;
        end else if (rd_status) begin
            armed_done_q <= prdata_q[ST_DONE_BIT] && done_flag_q; // Arm only on what software saw
            armed_write_collision_flag_q <= prdata_q[ST_WRITE_COLLISION_FLAG_BIT] && write_collision_flag_flag_q;
            armed_mode_fault_flag_q <= prdata_q[ST_MODE_FAULT_FLAG_BIT] && mode_fault_flag_flag_q;
        end else begin
            if (data_acc) begin
                armed_done_q <= 1'b0;
                armed_write_collision_flag_q <= 1'b0;
            end
            if (wr_ctrl) begin
                armed_mode_fault_flag_q <= 1'b0;
            end
        end
    end

    // Set wins over clear
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            done_flag_q <= 1'b0;
            write_collision_flag_flag_q <= 1'b0;
            mode_fault_flag_flag_q <= 1'b0;
        end else begin
            if (done) begin
                done_flag_q <= 1'b1;
            end else if (data_acc && armed_done_q) begin
                done_flag_q <= 1'b0;
            end
            if (write_collision_flag_set) begin
                write_collision_flag_flag_q <= 1'b1;
            end else if (data_acc && armed_write_collision_flag_q) begin
                write_collision_flag_flag_q <= 1'b0;
            end
            if (dir_q[PIN_SS]) begin
                mode_fault_flag_flag_q <= 1'b0;
            end else if (mode_fault_flag_set) begin
                mode_fault_flag_flag_q <= 1'b1;
            end else if (wr_ctrl && armed_mode_fault_flag_q) begin
                mode_fault_flag_flag_q <= 1'b0;
            end
        end
    end

    // Interrupt request, no collision term
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= ctrl_q[C1_IRQ_EN] && (done_flag_q || mode_fault_flag_flag_q);
        end
    end

    // ----------------------------------------
    // Transfer engine
    // ----------------------------------------
    assign busy = (state_q != ST_IDLE);
    assign tick = master && (div_cnt_q == 8'(SCK_HALF_CYC - 1));
    assign lead_ev = master ? tick : ((pin_s[PIN_SCK] != sck_prev_q) && (pin_s[PIN_SCK] != ctrl_q[C1_CPOL]));
    assign trail_ev = master ? tick : ((pin_s[PIN_SCK] != sck_prev_q) && (pin_s[PIN_SCK] == ctrl_q[C1_CPOL]));
    assign abort = !enable || mode_fault_flag_set || (!master && pin_s[PIN_SS]);
    assign start = enable && !busy && (master ? (wr_data && !mode_fault_flag_set) : !pin_s[PIN_SS]);
    assign sample = (state_q == ST_LEAD) && lead_ev && !abort;
    assign shift = (state_q == ST_TRAIL) && trail_ev && !abort;
    assign done = (state_q == ST_DONE);

    // Half-period divider for master clock
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            div_cnt_q <= '0;
        end else if (!busy || tick) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
        end
    end

    // Serial clock edge history
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= pin_s[PIN_SCK];
        end
    end

    // Eight lead/trail pairs per byte
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    bit_cnt_q <= '0;
                    if (start) begin
                        state_q <= ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    if (abort) begin
                        state_q <= ST_IDLE;
                    end else if (lead_ev) begin
                        state_q <= ST_TRAIL;
                    end
                end
                ST_TRAIL: begin
                    if (abort) begin
                        state_q <= ST_IDLE;
                    end else if (trail_ev) begin
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        state_q <= (bit_cnt_q == LAST_BIT) ? ST_DONE : ST_LEAD;
                    end
                end
                ST_DONE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Received byte buffer, no reset
    always_ff @(posedge i_clock) begin
        if (done) begin
            rx_buf_q <= shift_data;
        end
    end

    // Shifter: idle writes load, busy writes dropped
    ssdp_shifter u_shifter (
        .i_clock(i_clock),
        .i_load(wr_data && !busy),
        .i_load_data(i_pwdata[BYTE_W-1:0]),
        .i_sample(sample),
        .i_shift(shift),
        .i_serial_in(master ? pin_s[PIN_MISO] : pin_s[PIN_MOSI]),
        .i_lsb_first(ctrl_q[C1_LSB_FIRST]),
        .o_serial_out(ser_out),
        .o_data(shift_data)
    );

    // ----------------------------------------
    // Shared port pins
    // ----------------------------------------
    ssdp_sync #(.W(BYTE_W)) u_pin_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async(i_pin_in),
        .o_sync(pin_s)
    );

    // Pin ownership: latch by default, serial units override
    always_comb begin
        pin_out_d = port_q;
        pin_oe_d = dir_q;
        if (i_async_rx_en) begin
            pin_oe_d[PIN_RX0] = 1'b0;
            pin_oe_d[PIN_RX1] = 1'b0;
        end
        if (i_async_tx_en) begin
            pin_oe_d[PIN_TX0] = 1'b1;
            pin_oe_d[PIN_TX1] = 1'b1;
            pin_out_d[PIN_TX0] = i_async_txd[0];
            pin_out_d[PIN_TX1] = i_async_txd[1];
        end
        if (enable && master) begin
            pin_oe_d[PIN_MISO] = 1'b0;
            pin_out_d[PIN_MOSI] = ser_out;
            pin_out_d[PIN_SCK] = ctrl_q[C1_CPOL] ^ (state_q == ST_TRAIL);
            if (dir_q[PIN_SS] && ctrl_q[C1_SS_OUT_EN]) begin
                pin_out_d[PIN_SS] = !busy;
            end
        end else if (enable) begin
            pin_oe_d[PIN_MOSI] = 1'b0;
            pin_oe_d[PIN_SCK] = 1'b0;
            pin_oe_d[PIN_SS] = 1'b0;
            pin_out_d[PIN_MISO] = ser_out;
            pin_oe_d[PIN_MISO] = dir_q[PIN_MISO] && !pin_s[PIN_SS];
        end
    end

    // Registered pin drivers
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pin_out_q <= '0;
            pin_oe_q <= '0;
        end else begin
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_pin_out = pin_out_q;
    assign o_pin_oe = pin_oe_q;
    assign o_spi_irq = irq_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_last_trail;
        (state_q == ST_TRAIL) && trail_ev && !abort && (bit_cnt_q == LAST_BIT);
    endsequence

    sequence s_armed_access;
        data_acc && armed_done_q && !done;
    endsequence

    a_done_after_eight: assert property (@(posedge i_clock) disable iff (i_rst)
        s_last_trail |-> ##2 done_flag_q)
        else $error("done flag not set after eighth clock");

    a_done_clear_seq: assert property (@(posedge i_clock) disable iff (i_rst)
        s_armed_access |=> !done_flag_q)
        else $error("done flag not cleared by armed access");

    a_busy_write_drop: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_data && busy && !shift |=> write_collision_flag_flag_q && $stable(shift_data))
        else $error("busy write not dropped");

    a_write_collision_flag_clear_seq: assert property (@(posedge i_clock) disable iff (i_rst)
        data_acc && armed_write_collision_flag_q && !write_collision_flag_set |=> !write_collision_flag_flag_q)
        else $error("collision flag not cleared");

    a_status_write_nop: assert property (@(posedge i_clock) disable iff (i_rst)
        acc && i_pwrite && (idx == IDX_STATUS) |=> $stable(ctrl_q) && !$fell(done_flag_q))
        else $error("status write changed state");

    a_unarmed_keep: assert property (@(posedge i_clock) disable iff (i_rst)
        data_acc && !armed_done_q && done_flag_q |=> done_flag_q)
        else $error("unarmed access cleared done flag");

    a_fault_inhibit: assert property (@(posedge i_clock) disable iff (i_rst)
        dir_q[PIN_SS] |=> !mode_fault_flag_flag_q)
        else $error("fault flag set with pin seven output");

    a_fault_dir_clear: assert property (@(posedge i_clock) disable iff (i_rst)
        mode_fault_flag_set |=> (dir_q[PIN_SS:PIN_MOSI] == 3'h0) && !ctrl_q[C1_MASTER] && !ctrl_q[C1_ENABLE])
        else $error("fault did not clear direction or mode");

    a_irq_follow: assert property (@(posedge i_clock) disable iff (i_rst)
        ctrl_q[C1_IRQ_EN] && done_flag_q |=> o_spi_irq)
        else $error("interrupt not raised");

    a_rx_pins_input: assert property (@(posedge i_clock) disable iff (i_rst)
        i_async_rx_en |=> !o_pin_oe[PIN_RX0] && !o_pin_oe[PIN_RX1])
        else $error("receiver pins driven");

    a_slave_select_in: assert property (@(posedge i_clock) disable iff (i_rst)
        enable && !master |=> !o_pin_oe[PIN_SS])
        else $error("slave select pin driven in slave mode");
endmodule

/* sim/ssdp_spi_peer.sv */
/*
 * SPI peer device for the bench: clock polarity 0, clock phase 0.
 * Assumes SCK, MOSI and select come from the block's port pins.
 */
`timescale 1ns/1ns
module ssdp_spi_peer (
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic i_sel_n,
    input wire logic [7:0] i_tx_byte,
    output logic o_miso,
    output logic [7:0] o_rx_byte
);
    logic [7:0] shift_q;

    // Load on select, first bit out before the lead edge
    always @(negedge i_sel_n) begin
        shift_q = i_tx_byte;
        o_miso = shift_q[7];
    end
    // Sample on lead edge, next bit out on trail edge
    always @(posedge i_sck) if (!i_sel_n) o_rx_byte = {o_rx_byte[6:0], i_mosi};
    always @(negedge i_sck) if (!i_sel_n) begin
        shift_q = {shift_q[6:0], 1'b0};
        o_miso = shift_q[7];
    end
    // Released line shows the inverse of its last level
    always @(posedge i_sel_n) o_miso = ~o_miso;
endmodule

/* sim/testbench.sv */
/*
 * Self-checking bench: APB master tasks, one task per scenario.
 * Assumes the SPI peer model and a resolved pin level for every port pin.
 */
`timescale 1ns/1ns
module testbench;
    import ssdp_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, miso, err;
    logic [7:0] pin_in, pin_out, pin_oe, peer_rx, rd;
    logic [7:0] ext_lvl = 8'hB6;
    logic rx_en = 1'b0;
    logic tx_en = 1'b0;
    logic [1:0] txd = 2'b10;
    int failures = 0;
    int n_compared = 0;

    always #5 i_clock = ~i_clock;
    // Pin level: driver when enabled, else outside world
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & {ext_lvl[7:5], miso, ext_lvl[3:0]});

    ssdp_top DUT (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_async_rx_en(rx_en),
        .i_async_tx_en(tx_en), .i_async_txd(txd), .o_spi_irq(irq));
    ssdp_spi_peer peer (.i_sck(pin_in[6]), .i_mosi(pin_in[5]), .i_sel_n(pin_in[7]),
        .i_tx_byte(8'h3C), .o_miso(miso), .o_rx_byte(peer_rx));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("Compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; result lands in rd and err
    task automatic apb(input int wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        psel <= 1'b1;
        pwr <= wr[0];
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge i_clock);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            tally_and_finish();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge i_clock);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        apb(0, IDX_STATUS, 8'h00);
        chk("status", rd, 8'h00);
        apb(0, IDX_DIR, 8'h00);
        chk("direction", rd, 8'h00);
        chk("pin enables", pin_oe, 8'h00);
        apb(1, IDX_STATUS, 8'hFF);
        apb(0, IDX_STATUS, 8'h00);
        chk("status after write", rd, 8'h00);
        apb(0, 8'h10, 8'h00);
        chk("unmapped error", {7'h00, err}, 8'h01);
        $display("reset test done");
    endtask

    task automatic test_transfer();
        int n;
        apb(1, IDX_DIR, 8'hE0);
        apb(1, IDX_CTRL_ONE, 8'h52);
        apb(1, IDX_DATA, 8'hA5);
        apb(1, IDX_DATA, 8'h11);
        n = 0;
        do begin
            apb(0, IDX_STATUS, 8'h00);
            n++;
        end while (rd[7] !== 1'b1 && n < 60);
        chk("status after byte", rd, 8'hC0);
        chk("peer received", peer_rx, 8'hA5);
        apb(0, IDX_DATA, 8'h00);
        chk("received byte", rd, 8'h3C);
        apb(0, IDX_STATUS, 8'h00);
        chk("status cleared", rd, 8'h00);
        $display("transfer test done");
    endtask

    task automatic test_fault();
        apb(1, IDX_CTRL_ONE, 8'h50);
        ext_lvl[7] <= 1'b0;
        apb(0, IDX_STATUS, 8'h00);
        chk("fault held off", rd, 8'h00);
        apb(1, IDX_DIR, 8'h60);
        repeat (4) @(posedge i_clock);
        apb(0, IDX_STATUS, 8'h00);
        chk("fault status", rd, 8'h10);
        apb(0, IDX_DIR, 8'h00);
        chk("direction forced", rd, 8'h00);
        apb(0, IDX_CTRL_ONE, 8'h00);
        chk("control in fault", rd, 8'h00);
        ext_lvl[7] <= 1'b1;
        apb(1, IDX_CTRL_ONE, 8'h00);
        apb(0, IDX_STATUS, 8'h00);
        chk("fault cleared", rd, 8'h00);
        $display("fault test done");
    endtask

    task automatic test_port();
        apb(1, IDX_PORT, 8'h0F);
        apb(1, IDX_DIR, 8'h0F);
        @(posedge i_clock);
        chk("pin enables", pin_oe, 8'h0F);
        chk("pin drivers", pin_out & 8'h0F, 8'h0F);
        apb(0, IDX_PORT, 8'h00);
        chk("port read", rd & 8'hEF, {ext_lvl[7:5], 5'h0F});
        rx_en <= 1'b1;
        tx_en <= 1'b1;
        repeat (4) @(posedge i_clock);
        chk("serial enables", pin_oe, 8'h0A);
        chk("serial drivers", pin_out & 8'h0A, 8'h08);
        $display("port test done");
    endtask

    task automatic test_slave();
        logic [7:0] sent;
        logic [7:0] seen;
        sent = 8'h5A;
        seen = 8'h00;
        apb(1, IDX_CTRL_ONE, 8'h40);
        apb(1, IDX_DIR, 8'hD0);
        apb(1, IDX_DATA, 8'hC3);
        // Select low, then eight serial clock periods of 80 ns
        ext_lvl[7] <= 1'b0;
        repeat (4) @(posedge i_clock);
        chk("slave pin enables", pin_oe, 8'h10);
        for (int b = 7; b >= 0; b--) begin
            ext_lvl[6:5] <= {1'b0, sent[b]};
            repeat (4) @(posedge i_clock);
            ext_lvl[6] <= 1'b1;
            repeat (2) @(posedge i_clock);
            seen[b] = pin_out[PIN_MISO];
            repeat (2) @(posedge i_clock);
        end
        ext_lvl[6] <= 1'b0;
        repeat (8) @(posedge i_clock);
        ext_lvl[7] <= 1'b1;
        repeat (4) @(posedge i_clock);
        chk("slave sent", seen, 8'hC3);
        apb(0, IDX_STATUS, 8'h00);
        chk("slave status", rd, 8'h80);
        apb(0, IDX_DATA, 8'h00);
        chk("slave received", rd, 8'h5A);
        apb(1, IDX_CTRL_ONE, 8'h00);
        apb(1, IDX_DIR, 8'h00);
        $display("slave test done");
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        test_reset();
        test_transfer();
        test_fault();
        test_slave();
        test_port();
        tally_and_finish();
    end
endmodule
